//--- include/port_alt_pkg.sv
// Shared constants for the port pin override logic and its controller.
package port_alt_pkg;
  localparam int NUM_PINS = 4;
  // Port register indices; byte address on the bus is four times these.
  localparam logic [1:0] IDX_PIN = 2'h0;
  localparam logic [1:0] IDX_DIR = 2'h1;
  localparam logic [1:0] IDX_OUT = 2'h2;
  localparam logic [1:0] IDX_PULLUP = 2'h3;
  // Controller register byte offsets.
  localparam logic [7:0] OFS_PIN = 8'h00;
  localparam logic [7:0] OFS_DIR = 8'h04;
  localparam logic [7:0] OFS_OUT = 8'h08;
  localparam logic [7:0] OFS_PULLUP = 8'h0C;
  localparam logic [7:0] OFS_CTRL = 8'h10;
  localparam logic [7:0] OFS_TIMER = 8'h14;
  localparam logic [7:0] OFS_PCFLAG = 8'h18;
  localparam logic [7:0] OFS_CAPTURE = 8'h1C;
  // Control register field positions.
  localparam int CTRL_CMP_A_EN = 0;
  localparam int CTRL_CMP_B_EN = 1;
  localparam int CTRL_CLK_FUSE = 2;
  localparam int CTRL_EXT_CLK = 3;
  localparam int CTRL_PC_GROUP = 4;
  localparam int CTRL_PC_MASK = 8;
  localparam int CTRL_W = 12;
  localparam int CAPTURE_W = 16;
  // Values after reset.
  localparam logic [3:0] PORT_RESET = 4'h0;
  localparam logic [CTRL_W-1:0] CTRL_RESET = 12'h000;
  // Pin roles.
  localparam int PIN_CMP_A = 0;
  localparam int PIN_CMP_B = 1;
  localparam int PIN_CAPTURE = 1;
  localparam int PIN_CLK_OUT = 2;
endpackage

//--- include/port_alt_if.sv
// Override and port register signals between pad logic and peripherals.
`timescale 1ns/1ps
interface port_alt_if;
  import port_alt_pkg::*;
  logic [NUM_PINS-1:0] pullup_override_en;
  logic [NUM_PINS-1:0] pullup_override_val;
  logic [NUM_PINS-1:0] dir_override_en;
  logic [NUM_PINS-1:0] dir_override_val;
  logic [NUM_PINS-1:0] value_override_en;
  logic [NUM_PINS-1:0] value_override_val;
  logic [NUM_PINS-1:0] toggle_override_en;
  logic [NUM_PINS-1:0] input_en_override_en;
  logic [NUM_PINS-1:0] input_en_override_val;
  logic [NUM_PINS-1:0] alt_digital_input;
  logic sleep_clamp;
  logic wr_strobe;
  logic [1:0] wr_sel;
  logic [NUM_PINS-1:0] wr_data;
  logic rd_strobe;
  logic [1:0] rd_sel;
  logic [NUM_PINS-1:0] rd_data;

  modport pad (
    input pullup_override_en, pullup_override_val,
    input dir_override_en, dir_override_val,
    input value_override_en, value_override_val, toggle_override_en,
    input input_en_override_en, input_en_override_val, sleep_clamp,
    input wr_strobe, wr_sel, wr_data, rd_strobe, rd_sel,
    output alt_digital_input, rd_data
  );
  modport periph (
    output pullup_override_en, pullup_override_val,
    output dir_override_en, dir_override_val,
    output value_override_en, value_override_val, toggle_override_en,
    output input_en_override_en, input_en_override_val, sleep_clamp,
    output wr_strobe, wr_sel, wr_data, rd_strobe, rd_sel,
    input alt_digital_input, rd_data
  );
endinterface // port_alt_if

//--- hw/port_pad_ctrl.sv
// Port pad logic: port registers, override muxes and input tap.
//
// Behaviour
// R1: Pull-up follows override value, else register bit.
// R2: Direction override value replaces direction bit.
// R3: Without override, direction bit enables driver.
// R4: Value override drives pin while driver on.
// R5: Without value override, output bit drives pin.
// R6: Toggle override inverts the output value bit.
// R7: Input enable follows override value always.
// R8: Without override, sleep clamps the input.
// R9: Alternate input tapped before port synchroniser.
// R10: Strobes per port, sleep shared, overrides per pin.
// R11: Software sets pin 0 output for compare A.
// R12: Software sets pin 1 output for compare B.
// R13: Pins 0 to 3 feed pin-change sources.
// R14: Pin 1 input triggers timer capture.
// R15: Comparator pins should be inputs, pull-up off.
// R16: Clock fuse makes pin 2 drive clock.
// R17: Driver off leaves pin undriven, overrides ignored.
`timescale 1ns/1ps
module port_pad_ctrl
  import port_alt_pkg::*;
(
  input wire logic clk,
  input wire logic reset_n,
  port_alt_if.pad bus,
  input wire logic [port_alt_pkg::NUM_PINS-1:0] pad_in,
  output logic [port_alt_pkg::NUM_PINS-1:0] pad_out,
  output logic [port_alt_pkg::NUM_PINS-1:0] pad_oe,
  output logic [port_alt_pkg::NUM_PINS-1:0] pad_pullup,
  output logic [port_alt_pkg::NUM_PINS-1:0] pin_state
);
  import port_alt_pkg::*;

  ////////////////////////////////////////////////////////////////////////
  // State.

  typedef struct packed {
    logic [NUM_PINS-1:0] pullup_bits;
    logic [NUM_PINS-1:0] dir_bits;
    logic [NUM_PINS-1:0] out_bits;
    logic [NUM_PINS-1:0] tap;
    logic [NUM_PINS-1:0] pin_sync;
    logic [NUM_PINS-1:0] drive_val;
    logic [NUM_PINS-1:0] drive_en;
    logic [NUM_PINS-1:0] pull_en;
    logic [NUM_PINS-1:0] input_en;
    logic [NUM_PINS-1:0] read_data;
  } pad_state_t;

  pad_state_t state;
  pad_state_t next_state;
  logic [NUM_PINS-1:0] eff_dir;
  logic [NUM_PINS-1:0] eff_val;

  ////////////////////////////////////////////////////////////////////////
  // Next-state logic.

  // Register writes come first so a toggle in the same cycle acts on the
  // freshly written value rather than being lost.
  always_comb begin
    next_state = state;
    eff_dir = '0;
    eff_val = '0;
    // R10 shared port strobes
    if (bus.wr_strobe) begin
      unique case (bus.wr_sel)
        IDX_PIN: next_state.out_bits = state.out_bits ^ bus.wr_data;
        IDX_DIR: next_state.dir_bits = bus.wr_data;
        IDX_OUT: next_state.out_bits = bus.wr_data;
        IDX_PULLUP: next_state.pullup_bits = bus.wr_data;
      endcase
    end
    // R6 toggle inverts bit
    next_state.out_bits = next_state.out_bits ^ bus.toggle_override_en;

    // Per-pin override muxes; every override input is per pin.
    for (int i = 0; i < NUM_PINS; i++) begin
      // R1 pull-up select
      next_state.pull_en[i] = bus.pullup_override_en[i] ?
        bus.pullup_override_val[i] : state.pullup_bits[i];
      // R2 R3 R16 driver enable select
      eff_dir[i] = bus.dir_override_en[i] ?
        bus.dir_override_val[i] : state.dir_bits[i];
      // R4 R5 R16 driven value select
      eff_val[i] = bus.value_override_en[i] ?
        bus.value_override_val[i] : state.out_bits[i];
      // R7 R8 input enable select
      next_state.input_en[i] = bus.input_en_override_en[i] ?
        bus.input_en_override_val[i] : !bus.sleep_clamp;
    end

    // R17 undriven when disabled
    next_state.drive_en = eff_dir;
    next_state.drive_val = eff_val & eff_dir;

    // The clamp forces a disabled input low, so a floating pad cannot
    // make the input stage burn current while asleep.
    // R9 tap before synchroniser
    next_state.tap = pad_in & state.input_en;
    next_state.pin_sync = state.tap;

    // Read answers one cycle after the strobe and shows the value after
    // any write of the same cycle, so back to back access is coherent.
    if (bus.rd_strobe) begin
      unique case (bus.rd_sel)
        IDX_PIN: next_state.read_data = state.pin_sync;
        IDX_DIR: next_state.read_data = next_state.dir_bits;
        IDX_OUT: next_state.read_data = next_state.out_bits;
        IDX_PULLUP: next_state.read_data = next_state.pullup_bits;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // State register.

  // Reset leaves every pin tri-stated with pull-ups off.
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      state <= '0;
    end else begin
      state <= next_state;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Outputs.

  // The tap flop is only the first sampling stage; consumers must add
  // their own second stage before using it as anything but a clock.
  // R13 R14 input fan-out
  assign bus.alt_digital_input = state.tap;
  assign bus.rd_data = state.read_data;
  assign pad_out = state.drive_val;
  assign pad_oe = state.drive_en;
  assign pad_pullup = state.pull_en;
  assign pin_state = state.pin_sync;

endmodule // port_pad_ctrl

//--- hw/periph_override_ctrl.sv
// AHB-Lite controlled peripheral side producing the pin override signals.
//
// Our own choices: the register offsets and register access over AHB-Lite.
`timescale 1ns/1ps
module periph_override_ctrl
  import port_alt_pkg::*;
(
  input wire logic clk,
  input wire logic reset_n,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic [31:0] hrdata,
  output logic hresp,
  input wire logic power_down,
  output logic capture_pulse,
  port_alt_if.periph ovr
);
  import port_alt_pkg::*;

  typedef enum logic [1:0] {ST_IDLE, ST_RD_ISSUE, ST_RD_TAKE} bus_st_t;

  typedef struct packed {
    bus_st_t st;
    logic a_valid;
    logic a_write;
    logic [7:0] a_addr;
    logic rdy;
    logic [31:0] rdata;
    logic [CTRL_W-1:0] ctrl;
    logic [1:0] cmp_level;
    logic [NUM_PINS-1:0] pc_flags;
    logic [CAPTURE_W-1:0] capture;
    logic [CAPTURE_W-1:0] count;
    logic cap_pulse;
    logic clk_half;
    logic [NUM_PINS-1:0] di_s2;
    logic [NUM_PINS-1:0] di_prev;
    logic sleep;
    logic [NUM_PINS-1:0] pu_oe, pu_ov, dd_oe, dd_ov, pv_oe, pv_ov, ie_oe, ie_ov;
    logic wr_stb;
    logic [1:0] wr_sel;
    logic [NUM_PINS-1:0] wr_data;
    logic rd_stb;
    logic [1:0] rd_sel;
  } ctl_state_t;

  ctl_state_t s;
  ctl_state_t next_s;
  logic [NUM_PINS-1:0] di_s1;
  logic [NUM_PINS-1:0] pc_en;
  logic [NUM_PINS-1:0] pc_set;
  logic take;
  logic fuse;
  logic ext;

  ////////////////////////////////////////////////////////////////////////
  // First synchroniser stage, read only by the second stage.

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      di_s1 <= '0;
    end else begin
      di_s1 <= ovr.alt_digital_input;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Next-state logic.

  // Port register reads wait for the pad side; own registers answer at once.
  always_comb begin
    next_s = s;
    take = hsel && htrans[1] && hready;
    fuse = s.ctrl[CTRL_CLK_FUSE];
    ext = s.ctrl[CTRL_EXT_CLK];
    pc_en = s.ctrl[CTRL_PC_MASK +: NUM_PINS] &
      {NUM_PINS{s.ctrl[CTRL_PC_GROUP]}};
    next_s.wr_stb = 1'b0;
    next_s.rd_stb = 1'b0;
    next_s.cap_pulse = 1'b0;
    next_s.count = s.count + 16'h0001;
    next_s.clk_half = !s.clk_half;
    next_s.sleep = power_down;

    // R9 own second stage
    next_s.di_s2 = di_s1;
    next_s.di_prev = s.di_s2;
    // R13 change per source
    pc_set = (s.di_s2 ^ s.di_prev) & pc_en;
    // R14 rising edge capture
    if (s.di_s2[PIN_CAPTURE] && !s.di_prev[PIN_CAPTURE]) begin
      next_s.capture = s.count;
      next_s.cap_pulse = 1'b1;
    end

    // Data phase of a write: a set in the same cycle outlives the clear.
    if (s.a_valid && s.a_write) begin
      unique case (s.a_addr)
        OFS_PIN, OFS_DIR, OFS_OUT, OFS_PULLUP: begin
          next_s.wr_stb = 1'b1;
          next_s.wr_sel = s.a_addr[3:2];
          next_s.wr_data = hwdata[NUM_PINS-1:0];
        end
        OFS_CTRL: next_s.ctrl = hwdata[CTRL_W-1:0];
        OFS_TIMER: next_s.cmp_level = hwdata[1:0];
        OFS_PCFLAG: next_s.pc_flags = s.pc_flags & ~hwdata[NUM_PINS-1:0];
        default: ;
      endcase
    end
    next_s.pc_flags = next_s.pc_flags | pc_set;

    next_s.a_valid = 1'b0;
    unique case (s.st)
      ST_IDLE: begin
        if (take) begin
          next_s.a_valid = 1'b1;
          next_s.a_write = hwrite;
          next_s.a_addr = {haddr[7:2], 2'b00};
          next_s.rdata = '0;
          if (!hwrite && haddr[7:4] == 4'h0) begin
            next_s.rd_stb = 1'b1;
            next_s.rd_sel = haddr[3:2];
            next_s.rdy = 1'b0;
            next_s.st = ST_RD_ISSUE;
          end else if (!hwrite) begin
            unique case ({haddr[7:2], 2'b00})
              OFS_CTRL: next_s.rdata = 32'(s.ctrl);
              OFS_TIMER: next_s.rdata = 32'(s.cmp_level);
              OFS_PCFLAG: next_s.rdata = 32'(s.pc_flags);
              OFS_CAPTURE: next_s.rdata = 32'(s.capture);
              default: next_s.rdata = '0;
            endcase
          end
        end
      end
      ST_RD_ISSUE: next_s.st = ST_RD_TAKE;
      ST_RD_TAKE: begin
        next_s.rdata = 32'(ovr.rd_data);
        next_s.rdy = 1'b1;
        next_s.st = ST_IDLE;
      end
      default: next_s.st = ST_IDLE;
    endcase

    // Override generation per pin; pin 3 has only pin-change duties.
    next_s.pu_oe = '0;
    next_s.pu_ov = '0;
    next_s.dd_oe = '0;
    next_s.dd_ov = '0;
    next_s.pv_oe = '0;
    next_s.pv_ov = '0;
    // R11 compare A value
    next_s.pv_oe[PIN_CMP_A] = s.ctrl[CTRL_CMP_A_EN];
    next_s.pv_ov[PIN_CMP_A] = s.cmp_level[0];
    // R12 compare B value
    next_s.pv_oe[PIN_CMP_B] = ext || s.ctrl[CTRL_CMP_B_EN];
    // An external clock owns pin 1, so the compare level is masked then.
    next_s.pv_ov[PIN_CMP_B] = !ext && s.cmp_level[1];
    next_s.pu_oe[PIN_CMP_B] = ext;
    next_s.dd_oe[PIN_CMP_B] = ext;
    // R16 clock output pin
    next_s.pu_oe[PIN_CLK_OUT] = fuse;
    next_s.dd_oe[PIN_CLK_OUT] = fuse;
    next_s.dd_ov[PIN_CLK_OUT] = fuse;
    next_s.pv_oe[PIN_CLK_OUT] = fuse;
    next_s.pv_ov[PIN_CLK_OUT] = s.clk_half;
    // Pin-change sources keep their input alive through sleep.
    next_s.ie_oe = pc_en;
    next_s.ie_ov = pc_en;
    next_s.ie_oe[PIN_CMP_B] = ext || pc_en[PIN_CMP_B];
    // Pin 1 stays readable while its pin change is enabled; otherwise an external clock turns its input off except in power-down.
    next_s.ie_ov[PIN_CMP_B] = pc_en[PIN_CMP_B] || (ext && power_down);
  end

  ////////////////////////////////////////////////////////////////////////
  // State register.

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      s <= '{st: ST_IDLE, rdy: 1'b1, ctrl: CTRL_RESET, default: '0};
    end else begin
      s <= next_s;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Outputs from flops, except hresp and the toggle override, tied low. The clock pin carries clk/2, a flop-safe
  // stand-in for the system clock.

  assign hreadyout = s.rdy;
  assign hrdata = s.rdata;
  assign hresp = 1'b0;
  assign capture_pulse = s.cap_pulse;
  assign ovr.pullup_override_en = s.pu_oe;
  assign ovr.pullup_override_val = s.pu_ov;
  assign ovr.dir_override_en = s.dd_oe;
  assign ovr.dir_override_val = s.dd_ov;
  assign ovr.value_override_en = s.pv_oe;
  assign ovr.value_override_val = s.pv_ov;
  assign ovr.toggle_override_en = '0;
  assign ovr.input_en_override_en = s.ie_oe;
  assign ovr.input_en_override_val = s.ie_ov;
  assign ovr.sleep_clamp = s.sleep;
  assign ovr.wr_strobe = s.wr_stb;
  assign ovr.wr_sel = s.wr_sel;
  assign ovr.wr_data = s.wr_data;
  assign ovr.rd_strobe = s.rd_stb;
  assign ovr.rd_sel = s.rd_sel;

endmodule // periph_override_ctrl

//--- bench/port_alt_asserts.sv
// Concurrent checks on the pad link and the pad outputs of the port.
`timescale 1ns/1ps
module port_alt_asserts
  import port_alt_pkg::*;
(
  input wire logic clk,
  input wire logic reset_n,
  input wire logic [port_alt_pkg::NUM_PINS-1:0] pullup_override_en,
  input wire logic [port_alt_pkg::NUM_PINS-1:0] pullup_override_val,
  input wire logic [port_alt_pkg::NUM_PINS-1:0] dir_override_en,
  input wire logic [port_alt_pkg::NUM_PINS-1:0] dir_override_val,
  input wire logic [port_alt_pkg::NUM_PINS-1:0] value_override_en,
  input wire logic [port_alt_pkg::NUM_PINS-1:0] value_override_val,
  input wire logic [port_alt_pkg::NUM_PINS-1:0] toggle_override_en,
  input wire logic [port_alt_pkg::NUM_PINS-1:0] input_en_override_en,
  input wire logic [port_alt_pkg::NUM_PINS-1:0] input_en_override_val,
  input wire logic [port_alt_pkg::NUM_PINS-1:0] alt_digital_input,
  input wire logic sleep_clamp,
  input wire logic wr_strobe,
  input wire logic [1:0] wr_sel,
  input wire logic [port_alt_pkg::NUM_PINS-1:0] wr_data,
  input wire logic [port_alt_pkg::NUM_PINS-1:0] pad_in,
  input wire logic [port_alt_pkg::NUM_PINS-1:0] pad_out,
  input wire logic [port_alt_pkg::NUM_PINS-1:0] pad_oe,
  input wire logic [port_alt_pkg::NUM_PINS-1:0] pad_pullup,
  input wire logic [port_alt_pkg::NUM_PINS-1:0] pin_state
);
  logic [NUM_PINS-1:0] ie_on_q;
  logic [NUM_PINS-1:0] ie_off_q;
  logic sleep_q;
  logic [NUM_PINS-1:0] ie_hold;
  logic [NUM_PINS-1:0] clamp_hold;

  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);

  // Input enable registers inside the pad, so a setting must stand two
  // cycles before the input tap is judged by it.
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      ie_on_q <= '0;
      ie_off_q <= '0;
      sleep_q <= 1'b0;
    end else begin
      ie_on_q <= input_en_override_en & input_en_override_val;
      ie_off_q <= ~input_en_override_en;
      sleep_q <= sleep_clamp;
    end
  end

  // Pins whose enable setting has held for two cycles.
  assign ie_hold = input_en_override_en & input_en_override_val & ie_on_q;
  assign clamp_hold = ~input_en_override_en & ie_off_q &
                      {NUM_PINS{sleep_clamp & sleep_q}};

  sequence s_dir_write;
    wr_strobe && wr_sel == IDX_DIR ##1 dir_override_en == 4'h0;
  endsequence
  sequence s_out_write;
    wr_strobe && wr_sel == IDX_OUT && toggle_override_en == 4'h0
      ##1 value_override_en == 4'h0;
  endsequence

  a_pullup_override: assert property (|pullup_override_en |=>
    ((pad_pullup ^ $past(pullup_override_val)) &
     $past(pullup_override_en)) == 4'h0)
    else $error("pull-up ignores its override");
  a_dir_override: assert property (|dir_override_en |=>
    ((pad_oe ^ $past(dir_override_val)) & $past(dir_override_en)) == 4'h0)
    else $error("driver enable ignores its override");
  a_dir_from_reg: assert property (s_dir_write |=>
    pad_oe == $past(wr_data, 2))
    else $error("driver enable does not follow direction bits");
  a_value_override: assert property (|value_override_en |=>
    ((pad_out ^ $past(value_override_val)) & $past(value_override_en) &
     pad_oe) == 4'h0)
    else $error("driven level ignores value override");
  a_value_from_reg: assert property (s_out_write |=>
    ((pad_out ^ $past(wr_data, 2)) & pad_oe) == 4'h0)
    else $error("driven level does not follow output bits");
  a_input_override: assert property ($stable(pad_in) |=>
    ((alt_digital_input ^ $past(pad_in)) & $past(ie_hold)) == 4'h0)
    else $error("forced input enable not honoured");
  a_sleep_clamps: assert property (|clamp_hold |=>
    (alt_digital_input & $past(clamp_hold)) == 4'h0)
    else $error("input not clamped in sleep");
  a_sync_after_tap: assert property (##1 1'b1 |->
    pin_state == $past(alt_digital_input))
    else $error("synchroniser does not follow the input tap");
  a_undriven_low: assert property ((pad_out & ~pad_oe) == 4'h0)
    else $error("level driven while driver is off");
endmodule // port_alt_asserts

//--- bench/port_alternate_function_override_tb_top.sv
// Self-checking bench joining the pad logic and the override controller.
`timescale 1ns/1ps
module port_alternate_function_override_tb_top;
  import port_alt_pkg::*;
  logic clk, reset_n, hsel, hwrite, hready, hreadyout, power_down;
  logic capture_pulse;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [3:0] pad_in, pad_out, pad_oe, pad_pullup, pin_state;
  logic a, b;
  int miscompares = 0;
  int n_checks = 0;

  port_alt_if pif ();
  assign hready = hreadyout;
  port_pad_ctrl port_pad_ctrl_i (.clk(clk), .reset_n(reset_n), .bus(pif),
    .pad_in(pad_in), .pad_out(pad_out), .pad_oe(pad_oe),
    .pad_pullup(pad_pullup), .pin_state(pin_state));
  periph_override_ctrl periph_override_ctrl_i (.clk(clk), .reset_n(reset_n),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(hsize), .hwdata(hwdata), .hready(hready),
    .hreadyout(hreadyout), .hrdata(hrdata), .hresp(),
    .power_down(power_down), .capture_pulse(capture_pulse), .ovr(pif));
  port_alt_asserts port_alt_asserts_i (.clk(clk), .reset_n(reset_n),
    .pullup_override_en(pif.pullup_override_en),
    .pullup_override_val(pif.pullup_override_val),
    .dir_override_en(pif.dir_override_en),
    .dir_override_val(pif.dir_override_val),
    .value_override_en(pif.value_override_en),
    .value_override_val(pif.value_override_val),
    .toggle_override_en(pif.toggle_override_en),
    .input_en_override_en(pif.input_en_override_en),
    .input_en_override_val(pif.input_en_override_val),
    .alt_digital_input(pif.alt_digital_input),
    .sleep_clamp(pif.sleep_clamp), .wr_strobe(pif.wr_strobe),
    .wr_sel(pif.wr_sel), .wr_data(pif.wr_data), .pad_in(pad_in),
    .pad_out(pad_out), .pad_oe(pad_oe), .pad_pullup(pad_pullup),
    .pin_state(pin_state));

  //////////////////////////////////////////////////////////////////////////
  // Clock and closing report.
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  task automatic end_of_test();
    $display("checks %0d mismatches %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  //////////////////////////////////////////////////////////////////////////
  // Single AHB-Lite transfer; the wait count guards against a stuck slave.
  task automatic xfer(input logic w, input logic [7:0] ad,
                      input logic [31:0] wd, output logic [31:0] rdat);
    int n;
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= {24'h000000, ad};
    hwrite <= w;
    n = 0;
    do begin @(posedge clk); n++; end while (hreadyout !== 1'b1 && n < 50);
    // A stuck address phase is a mismatch and ends the run.
    if (hreadyout !== 1'b1) begin
      chk(32'h0, 32'h1);
      end_of_test();
    end
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    do begin @(posedge clk); n++; end while (hreadyout !== 1'b1 && n < 100);
    rdat = hrdata;
    if (hreadyout !== 1'b1) begin
      chk(32'h0, 32'h1);
      end_of_test();
    end
  endtask

  task automatic wr(input logic [7:0] ad, input logic [31:0] wd);
    xfer(1'b1, ad, wd, rd);
    repeat (4) @(posedge clk);
  endtask

  task automatic rd_chk(input logic [7:0] ad, input logic [31:0] exp);
    xfer(1'b0, ad, 32'h0, rd);
    chk(rd, exp);
  endtask

  //////////////////////////////////////////////////////////////////////////
  // Scenarios.
  task automatic sc_reset();
    chk({pad_oe, pad_out, pad_pullup}, 12'h000);
    rd_chk(OFS_CTRL, 32'h0);
    rd_chk(8'h20, 32'h0);
  endtask

  // Direction, output and toggle writes, then read-back of direction.
  task automatic sc_port_regs();
    wr(OFS_DIR, 32'h5);
    wr(OFS_OUT, 32'hF);
    chk({pad_oe, pad_out}, 8'h55);
    wr(OFS_PIN, 32'h5);
    chk(pad_out, 4'h0);
    rd_chk(OFS_DIR, 32'h5);
    wr(OFS_DIR, 32'h0);
    chk({pad_oe, pad_out}, 8'h00);
    // Comparator pins left as inputs with pull-ups off.
    chk(pad_pullup[1:0], 2'h0);
  endtask

  // Pull-up bits, then the clock-output fuse taking over pin 2.
  task automatic sc_pullup_clock();
    wr(OFS_PULLUP, 32'hE);
    chk(pad_pullup, 4'hE);
    wr(OFS_CTRL, 32'h4);
    chk(pad_pullup, 4'hA);
    chk(pad_oe, 4'h4);
    a = pad_out[2];
    @(posedge clk);
    b = pad_out[2];
    chk(a ^ b, 1'b1);
    wr(OFS_CTRL, 32'h0);
    wr(OFS_PULLUP, 32'h0);
  endtask

  // Compare outputs need their direction bits set to show on the pins.
  task automatic sc_compare();
    wr(OFS_DIR, 32'h3);
    wr(OFS_CTRL, 32'h3);
    wr(OFS_TIMER, 32'h1);
    chk(pad_out[1:0], 2'h1);
    wr(OFS_TIMER, 32'h2);
    chk(pad_out[1:0], 2'h2);
    // External clock takes pin 1: driver and pull-up forced off.
    wr(OFS_PULLUP, 32'h2);
    wr(OFS_CTRL, 32'h8);
    chk({pad_oe[1], pad_pullup[1]}, 2'h0);
    wr(OFS_PULLUP, 32'h0);
    wr(OFS_DIR, 32'h0);
    chk(pad_out[1:0], 2'h0);
    wr(OFS_CTRL, 32'h0);
  endtask

  // Pin change flags, capture trigger, and the sleep clamp.
  task automatic sc_inputs();
    int n;
    wr(OFS_CTRL, 32'hF10);
    wr(OFS_PCFLAG, 32'hF);
    pad_in <= 4'h2;
    n = 0;
    do begin @(posedge clk); n++; end while (capture_pulse !== 1'b1 && n < 20);
    chk(capture_pulse, 1'b1);
    // A capture that never comes ends the run.
    if (capture_pulse !== 1'b1) begin
      end_of_test();
    end
    repeat (4) @(posedge clk);
    rd_chk(OFS_PCFLAG, 32'h2);
    rd_chk(OFS_PIN, 32'h2);
    pad_in <= 4'hA;
    repeat (8) @(posedge clk);
    rd_chk(OFS_PCFLAG, 32'hA);
    wr(OFS_CTRL, 32'h0);
    power_down <= 1'b1;
    repeat (8) @(posedge clk);
    rd_chk(OFS_PIN, 32'h0);
    wr(OFS_CTRL, 32'hF10);
    repeat (4) @(posedge clk);
    rd_chk(OFS_PIN, 32'hA);
    power_down <= 1'b0;
    wr(OFS_CTRL, 32'h0);
  endtask

  //////////////////////////////////////////////////////////////////////////
  // Main sequence.
  initial begin
    reset_n = 1'b0;
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0;
    power_down = 1'b0;
    pad_in = 4'h0;
    repeat (3) @(posedge clk);
    reset_n <= 1'b1;
    @(posedge clk);
    sc_reset();
    sc_port_regs();
    sc_pullup_clock();
    sc_compare();
    sc_inputs();
    end_of_test();
  end
endmodule // port_alternate_function_override_tb_top
